// ===== common/supply_status_word_reporter_defines.vh
`ifndef SUPPLY_STATUS_WORD_REPORTER_DEFINES_VH
`define SUPPLY_STATUS_WORD_REPORTER_DEFINES_VH

`define ADDR_W          8
`define REG_CTRL        8'h00
`define REG_INTLK_WORD  8'h04
`define REG_SYS_WORD    8'h08
`define REG_COUNTS      8'h0c
`define REG_LATCHES     8'h10
`define REG_LAST_REPLY  8'h14
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET      1'b1
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`define LETTER_INTLK    8'h4b
`define LETTER_SYS      8'h53

`define IK_ESTOP        15
`define IK_REMOTE_OFF   14
`define IK_WATER        13
`define IK_VACUUM       12
`define IK_AUX          11
`define IK_KEY_OFF      8
`define IK_BUS_LOW      7
`define IK_BUS_HIGH     6
`define IK_SUMMARY      0

`define SY_METHOD_HI    15
`define SY_METHOD_LO    14
`define SY_PAUSED       13
`define SY_ARC          12
`define SY_RAMPING      11
`define SY_PLASMA       10
`define SY_AT_SETPOINT  9
`define SY_OUTPUT_ON    8
`define SY_TURNED_ON    7
`define SY_ATTENTION    6
`define SY_TARGET_END   5
`define SY_HOST_REMOTE  3
`define SY_USER_LEVEL   2
`define SY_USER_RAMP    1
`define SY_USER_ONOFF   0

`define METHOD_POWER    2'b00
`define METHOD_CURRENT  2'b01
`define METHOD_VOLTAGE  2'b10
`define FIELD_POWER     2'b10
`define FIELD_CURRENT   2'b01
`define FIELD_VOLTAGE   2'b11
`define FIELD_NONE      2'b00

`endif

// ===== src/axil_slave_port.v
`timescale 1ns/1ps
`include "supply_status_word_reporter_defines.vh"
module axil_slave_port (
    input  wire               aclk,
    input  wire               aresetn,
    input  wire [`ADDR_W-1:0] s_axi_awaddr,
    input  wire               s_axi_awvalid,
    output reg                s_axi_awready,
    input  wire [31:0]        s_axi_wdata,
    input  wire [3:0]         s_axi_wstrb,
    input  wire               s_axi_wvalid,
    output reg                s_axi_wready,
    output reg  [1:0]         s_axi_bresp,
    output reg                s_axi_bvalid,
    input  wire               s_axi_bready,
    input  wire [`ADDR_W-1:0] s_axi_araddr,
    input  wire               s_axi_arvalid,
    output reg                s_axi_arready,
    output reg  [31:0]        s_axi_rdata,
    output reg  [1:0]         s_axi_rresp,
    output reg                s_axi_rvalid,
    input  wire               s_axi_rready,
    output wire               wr_en,
    output wire [`ADDR_W-1:0] wr_addr,
    output wire [31:0]        wr_data,
    output wire [3:0]         wr_strb,
    input  wire               wr_err,
    output wire               rd_en,
    output wire [`ADDR_W-1:0] rd_addr,
    input  wire [31:0]        rd_data,
    input  wire               rd_err
);
    reg  [`ADDR_W-1:0] awaddr_q;
    reg  [31:0]        wdata_q;
    reg  [3:0]         wstrb_q;
    reg                aw_have_q;
    reg                w_have_q;

    // write fires once both address and data are held
    assign wr_en   = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign wr_addr = awaddr_q;
    assign wr_data = wdata_q;
    assign wr_strb = wstrb_q;
    assign rd_en   = s_axi_arvalid & s_axi_arready;
    assign rd_addr = s_axi_araddr;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= {`ADDR_W{1'b0}};
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
        end else begin
            if (!aw_have_q && !s_axi_bvalid)
                s_axi_awready <= ~(s_axi_awvalid & s_axi_awready);
            if (!w_have_q && !s_axi_bvalid)
                s_axi_wready <= ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_en) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (rd_en) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// ===== src/status_reply_serializer.v
`timescale 1ns/1ps
`include "supply_status_word_reporter_defines.vh"
module status_reply_serializer (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        load,
    input  wire [15:0] word,
    input  wire [7:0]  letter,
    output reg         reply_valid,
    output reg  [7:0]  reply_data,
    input  wire        reply_ready,
    output reg         last_sent
);
    wire [39:0] frame;
    reg  [31:0] rest_q;
    reg  [2:0]  left_q;

    // four ascii hex digits, leftmost from the top nibble, then the letter
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_hex
            wire [3:0] nib = word[4*i+3:4*i];
            assign frame[8*i+15:8*i+8] = (nib < 4'ha) ? (8'h30 + {4'h0, nib})
                                                      : (8'h37 + {4'h0, nib});
        end
    endgenerate
    assign frame[7:0] = letter;

    always @(posedge aclk) begin
        if (!aresetn) begin
            reply_valid <= 1'b0;
            reply_data  <= 8'h00;
            rest_q      <= 32'h0000_0000;
            left_q      <= 3'h0;
            last_sent   <= 1'b0;
        end else begin
            last_sent <= 1'b0;
            if (load && !reply_valid) begin
                reply_valid <= 1'b1;
                reply_data  <= frame[39:32];
                rest_q      <= frame[31:0];
                left_q      <= 3'h4;
            end else if (reply_valid && reply_ready) begin
                if (left_q == 3'h0) begin
                    reply_valid <= 1'b0;
                    last_sent   <= 1'b1;
                end else begin
                    reply_data <= rest_q[31:24];
                    rest_q     <= {rest_q[23:0], 8'h00};
                    left_q     <= left_q - 3'h1;
                end
            end
        end
    end
endmodule

// ===== src/supply_status_word_reporter.v
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "supply_status_word_reporter_defines.vh"
module supply_status_word_reporter (
    input  wire               aclk,
    input  wire               aresetn,
    input  wire [`ADDR_W-1:0] s_axi_awaddr,
    input  wire               s_axi_awvalid,
    output wire               s_axi_awready,
    input  wire [31:0]        s_axi_wdata,
    input  wire [3:0]         s_axi_wstrb,
    input  wire               s_axi_wvalid,
    output wire               s_axi_wready,
    output wire [1:0]         s_axi_bresp,
    output wire               s_axi_bvalid,
    input  wire               s_axi_bready,
    input  wire [`ADDR_W-1:0] s_axi_araddr,
    input  wire               s_axi_arvalid,
    output wire               s_axi_arready,
    output wire [31:0]        s_axi_rdata,
    output wire [1:0]         s_axi_rresp,
    output wire               s_axi_rvalid,
    input  wire               s_axi_rready,
    input  wire               estop_active,
    input  wire               remote_off_high,
    input  wire               water_unmet,
    input  wire               vacuum_unmet,
    input  wire               aux_unmet,
    input  wire               key_switch_off,
    input  wire               bus_volt_low,
    input  wire               bus_volt_high,
    input  wire               handshake_open,
    input  wire               arc_sensed,
    input  wire               ramp_paused,
    input  wire               ramp_active,
    input  wire               plasma_on,
    input  wire               setpoint_reached,
    input  wire               output_is_on,
    input  wire               run_time_over,
    input  wire               target_life_end,
    input  wire               host_remote,
    input  wire               user_level,
    input  wire               user_ramp,
    input  wire               user_onoff,
    input  wire [1:0]         reg_method,
    input  wire               host_takeover_command,
    input  wire               output_off_reset_command,
    input  wire               query_valid,
    input  wire [7:0]         query_letter,
    output reg                query_ready,
    output wire               reply_valid,
    output wire [7:0]         reply_data,
    input  wire               reply_ready
);
    // pins crossing into the clock domain
    localparam NPIN = 23;

    wire [NPIN-1:0] pin_raw;
    reg  [NPIN-1:0] pin_meta_q;
    reg  [NPIN-1:0] pin_sync_q;

    // method on top, then flags from user_onoff down to estop_active
    assign pin_raw = {reg_method, user_onoff, user_ramp, user_level, host_remote,
                      target_life_end, run_time_over, output_is_on, setpoint_reached,
                      plasma_on, ramp_active, ramp_paused, arc_sensed, handshake_open,
                      bus_volt_high, bus_volt_low, key_switch_off, aux_unmet,
                      vacuum_unmet, water_unmet, remote_off_high, estop_active};

    // two-stage synchroniser per pin
    genvar i;
    generate
        for (i = 0; i < NPIN; i = i + 1) begin : g_sync
            always @(posedge aclk) begin
                if (!aresetn) begin
                    pin_meta_q[i] <= 1'b0;
                    pin_sync_q[i] <= 1'b0;
                end else begin
                    pin_meta_q[i] <= pin_raw[i];
                    pin_sync_q[i] <= pin_meta_q[i];
                end
            end
        end
    endgenerate

    // synchronised pin levels
    wire       s_estop      = pin_sync_q[0];
    wire       s_remote_off = pin_sync_q[1];
    wire       s_water      = pin_sync_q[2];
    wire       s_vacuum     = pin_sync_q[3];
    wire       s_aux        = pin_sync_q[4];
    wire       s_key_off    = pin_sync_q[5];
    wire       s_bus_low    = pin_sync_q[6];
    wire       s_bus_high   = pin_sync_q[7];
    wire       s_handshake  = pin_sync_q[8];
    wire       s_arc        = pin_sync_q[9];
    wire       s_paused     = pin_sync_q[10];
    wire       s_ramping    = pin_sync_q[11];
    wire       s_plasma     = pin_sync_q[12];
    wire       s_at_setpt   = pin_sync_q[13];
    wire       s_out_on     = pin_sync_q[14];
    wire       s_run_over   = pin_sync_q[15];
    wire       s_target_end = pin_sync_q[16];
    wire       s_host_rem   = pin_sync_q[17];
    wire       s_user_level = pin_sync_q[18];
    wire       s_user_ramp  = pin_sync_q[19];
    wire       s_user_onoff = pin_sync_q[20];
    wire [1:0] s_method     = pin_sync_q[22:21];

    // latches, counters and the last reply
    reg         ctrl_enable_q;
    reg         takeover_pending_q;
    reg         arc_latched_q;
    reg         turned_on_q;
    reg  [15:0] reply_cnt_q;
    reg  [15:0] ignored_cnt_q;
    reg  [7:0]  last_letter_q;
    reg  [15:0] last_word_q;
    // status words as they are sent
    reg  [15:0] intlk_word;
    reg  [15:0] sys_word;
    reg  [1:0]  method_field;

    // a query counts only when taken with ready high
    wire        query_take  = query_valid & query_ready;
    wire        is_intlk_q  = (query_letter == `LETTER_INTLK);
    wire        is_sys_q    = (query_letter == `LETTER_SYS);
    wire        known_take  = query_take & (is_intlk_q | is_sys_q);
    wire        sys_take    = query_take & is_sys_q;
    wire [15:0] reply_word  = is_intlk_q ? intlk_word : sys_word;
    wire        reply_busy;
    wire        reply_done;

    // any of estop, water, vacuum, aux or key-switch interlocks unmet; remote-off and bus levels are not included
    wire        hw_interlock_unmet = s_estop | s_water | s_vacuum | s_aux | s_key_off;

    // latched conditions; a new event wins over a clear in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            takeover_pending_q <= 1'b0;
            arc_latched_q      <= 1'b0;
            turned_on_q        <= 1'b0;
        end else begin
            if (host_takeover_command)
                takeover_pending_q <= 1'b1;
            else if (output_off_reset_command)
                takeover_pending_q <= 1'b0;
            if (s_arc)
                arc_latched_q <= 1'b1;
            else if (sys_take)
                arc_latched_q <= 1'b0;
            if (s_out_on)
                turned_on_q <= 1'b1;
            else if (output_off_reset_command)
                turned_on_q <= 1'b0;
        end
    end

    // method code to reply field
    always @* begin
        case (s_method)
            `METHOD_POWER:   method_field = `FIELD_POWER;
            `METHOD_CURRENT: method_field = `FIELD_CURRENT;
            `METHOD_VOLTAGE: method_field = `FIELD_VOLTAGE;
            default:         method_field = `FIELD_NONE;
        endcase
    end

    // unlisted bits stay zero
    always @* begin
        intlk_word                 = 16'h0000;
        intlk_word[`IK_ESTOP]      = s_estop;
        intlk_word[`IK_REMOTE_OFF] = s_remote_off;
        intlk_word[`IK_WATER]      = s_water;
        intlk_word[`IK_VACUUM]     = s_vacuum;
        intlk_word[`IK_AUX]        = s_aux;
        intlk_word[`IK_KEY_OFF]    = s_key_off;
        intlk_word[`IK_BUS_LOW]    = s_bus_low;
        intlk_word[`IK_BUS_HIGH]   = s_bus_high;
        intlk_word[`IK_SUMMARY]    = hw_interlock_unmet | takeover_pending_q |
                                     s_handshake | s_bus_low;
    end

    always @* begin
        sys_word                  = 16'h0000;
        sys_word[`SY_METHOD_HI]   = method_field[1];
        sys_word[`SY_METHOD_LO]   = method_field[0];
        sys_word[`SY_PAUSED]      = s_paused;
        sys_word[`SY_ARC]         = arc_latched_q;
        sys_word[`SY_RAMPING]     = s_ramping;
        sys_word[`SY_PLASMA]      = s_plasma;
        sys_word[`SY_AT_SETPOINT] = s_at_setpt;
        sys_word[`SY_OUTPUT_ON]   = s_out_on;
        sys_word[`SY_TURNED_ON]   = turned_on_q;
        sys_word[`SY_ATTENTION]   = hw_interlock_unmet | takeover_pending_q |
                                    s_run_over;
        sys_word[`SY_TARGET_END]  = s_target_end;
        sys_word[`SY_HOST_REMOTE] = s_host_rem;
        sys_word[`SY_USER_LEVEL]  = s_user_level;
        sys_word[`SY_USER_RAMP]   = s_user_ramp;
        sys_word[`SY_USER_ONOFF]  = s_user_onoff;
    end

    // one query at a time; ready drops on the take of a known letter and returns after the reply
    always @(posedge aclk) begin
        if (!aresetn) begin
            query_ready   <= 1'b0;
            reply_cnt_q   <= 16'h0000;
            ignored_cnt_q <= 16'h0000;
            last_letter_q <= 8'h00;
            last_word_q   <= 16'h0000;
        end else begin
            query_ready <= ctrl_enable_q & ~reply_busy & ~known_take;
            if (known_take) begin
                last_letter_q <= query_letter;
                last_word_q   <= reply_word;
            end else if (query_take) begin
                ignored_cnt_q <= ignored_cnt_q + 16'h0001;
            end
            if (reply_done)
                reply_cnt_q <= reply_cnt_q + 16'h0001;
        end
    end

    // reply framing and byte handshake
    status_reply_serializer u_serializer (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .load        (known_take),
        .word        (reply_word),
        .letter      (query_letter),
        .reply_valid (reply_valid),
        .reply_data  (reply_data),
        .reply_ready (reply_ready),
        .last_sent   (reply_done)
    );
    assign reply_busy = reply_valid;

    // register bus; only the control word is writable
    wire               wr_en;
    wire [`ADDR_W-1:0] wr_addr;
    wire [31:0]        wr_data;
    wire [3:0]         wr_strb;
    wire               rd_en;
    wire [`ADDR_W-1:0] rd_addr;
    reg  [31:0]        rd_data;
    reg                rd_err;
    wire               wr_err = (wr_addr != `REG_CTRL);

    // reply enable, set out of reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_enable_q <= `CTRL_RESET;
        end else if (wr_en && !wr_err && wr_strb[0]) begin
            ctrl_enable_q <= wr_data[`CTRL_ENABLE_BIT];
        end
    end

    // read decode; unmapped offsets answer with an error
    always @* begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        case (rd_addr)
            `REG_CTRL:       rd_data[`CTRL_ENABLE_BIT] = ctrl_enable_q;
            `REG_INTLK_WORD: rd_data[15:0] = intlk_word;
            `REG_SYS_WORD:   rd_data[15:0] = sys_word;
            `REG_COUNTS:     rd_data = {ignored_cnt_q, reply_cnt_q};
            `REG_LATCHES:    rd_data[2:0] = {turned_on_q, arc_latched_q, takeover_pending_q};
            `REG_LAST_REPLY: rd_data[23:0] = {last_letter_q, last_word_q};
            default:         rd_err = 1'b1;
        endcase
    end

    // slave front end of the register bus
    axil_slave_port u_axil (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_err        (wr_err),
        .rd_en         (rd_en),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );
endmodule

// ===== dv/supply_status_word_reporter_asserts.sv
`timescale 1ns/1ps
module supply_status_word_reporter_asserts (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       estop_active,
    input wire logic       query_valid,
    input wire logic [7:0] query_letter,
    input wire logic       query_ready,
    input wire logic       reply_valid,
    input wire logic [7:0] reply_data,
    input wire logic       reply_ready
);
    logic [2:0] n_q;
    logic [7:0] let_q;
    wire        take = query_valid && query_ready;
    always @(posedge aclk) begin
        if (!aresetn || take) n_q <= 3'd0;
        else if (reply_valid && reply_ready) n_q <= n_q + 3'd1;
        if (take) let_q <= query_letter;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence k_take; take && query_letter == 8'h4b; endsequence
    sequence estop_k; estop_active [*6] ##0 k_take; endsequence
    sequence k_char(int c); reply_valid && n_q == c && let_q == 8'h4b; endsequence
    a_reply_hold: assert property (reply_valid && !reply_ready |=>
        reply_valid && $stable(reply_data)) else $error("reply byte moved while stalled");
    a_one_query: assert property (reply_valid |-> !query_ready)
        else $error("query accepted during a reply");
    a_reply_start: assert property (k_take |=> reply_valid && n_q == 3'd0)
        else $error("interlock reply did not start");
    a_hex_char: assert property (reply_valid && n_q < 3'd4 |->
        reply_data inside {[8'h30:8'h39], [8'h41:8'h46]}) else $error("reply char not hex");
    a_letter_last: assert property (reply_valid && n_q == 3'd4 |-> reply_data == let_q)
        else $error("fifth byte is not the query letter");
    a_five_bytes: assert property (reply_valid && reply_ready && n_q == 3'd4 |=>
        !reply_valid) else $error("reply longer than five bytes");
    a_estop_flag: assert property (estop_k |=>
        reply_data inside {8'h38, 8'h39, [8'h41:8'h46]}) else $error("stop flag missing");
    a_k_second: assert property (k_char(1) |->
        reply_data inside {8'h30, 8'h31, 8'h38, 8'h39}) else $error("second char bits set");
    a_k_third: assert property (k_char(2) |->
        reply_data inside {8'h30, 8'h34, 8'h38, 8'h43}) else $error("third char bits set");
endmodule
bind supply_status_word_reporter supply_status_word_reporter_asserts chk (.aclk(aclk),
    .aresetn(aresetn), .estop_active(estop_active), .query_valid(query_valid),
    .query_letter(query_letter), .query_ready(query_ready), .reply_valid(reply_valid),
    .reply_data(reply_data), .reply_ready(reply_ready));

// ===== dv/host_query_model.sv
`timescale 1ns/1ps
module host_query_model (
    input  wire logic       aclk,
    input  wire logic       query_ready,
    input  wire logic       reply_valid,
    input  wire logic [7:0] reply_data,
    output logic            query_valid = 1'b0,
    output logic [7:0]      query_letter = 8'h00,
    output logic            reply_ready = 1'b0
);
    // one query, then five bytes gathered leftmost first; slow stalls every other cycle
    task automatic ask(input logic [7:0] l, input logic slow, output logic [39:0] r);
        int t, n;
        t = 0;
        n = 0;
        r = 40'h0;
        query_valid <= 1'b1;
        query_letter <= l;
        do begin
            @(posedge aclk);
            t++;
        end while (!query_ready && t < 100);
        query_valid <= 1'b0;
        query_letter <= ~l;
        reply_ready <= 1'b1;
        while (n < 5 && t < 400) begin
            @(posedge aclk);
            t++;
            if (reply_valid && reply_ready) begin
                r = {r[31:0], reply_data};
                n++;
            end
            reply_ready <= n < 5 && (!slow || !reply_ready);
        end
    endtask
endmodule

// ===== dv/test_supply_status_word_reporter.sv
`timescale 1ns/1ps
module test_supply_status_word_reporter;
    logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        rs = 1'b0, tk = 1'b0, arc_l = 1'b0, on_l = 1'b0, tk_l = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        query_valid, query_ready, reply_valid, reply_ready;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, query_letter, reply_data;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, m = 2'b00;
    logic [1:0]  mf [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
    logic [20:0] p = 21'h0;
    logic [24:0] tbl [8] = '{25'h0, 25'h3fffff, 25'h4aaaaa, 25'h755555, 25'h100, 25'h80,
                             25'h800000, 25'h1000000};
    int          n_fail = 0, n_checks = 0;
    always #20 aclk = ~aclk;
    supply_status_word_reporter dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .estop_active(p[3]),
        .remote_off_high(p[2]), .water_unmet(p[1]), .vacuum_unmet(p[0]), .aux_unmet(p[4]),
        .key_switch_off(p[5]), .bus_volt_low(p[7]), .bus_volt_high(p[6]),
        .handshake_open(p[8]), .run_time_over(p[9]), .target_life_end(p[10]),
        .arc_sensed(p[11]), .ramp_paused(p[12]), .output_is_on(p[13]),
        .setpoint_reached(p[14]), .plasma_on(p[15]), .ramp_active(p[16]),
        .user_onoff(p[17]), .user_ramp(p[18]), .user_level(p[19]), .host_remote(p[20]),
        .reg_method(m), .host_takeover_command(tk), .output_off_reset_command(rs),
        .query_valid, .query_letter, .query_ready, .reply_valid, .reply_data, .reply_ready);
    host_query_model host (.aclk, .query_ready, .reply_valid, .reply_data, .query_valid,
                           .query_letter, .reply_ready);
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] hx(input logic [3:0] n);
        return n < 4'd10 ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction
    task automatic ax(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int t;
        t = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        do begin
            @(posedge aclk);
            t++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_bvalid || s_axi_rvalid) && t < 50);
        {s_axi_bready, s_axi_rready} <= 2'b00;
        chk("bus_timeout", 40'h0, 40'(t >= 50));
        chk("resp", 40'(er), 40'(wr ? s_axi_bresp : s_axi_rresp));
        if (!wr && er == 2'b00) chk("rdata", 40'(d), 40'(s_axi_rdata));
    endtask
    task automatic probe(input logic [7:0] l, input logic slow);
        logic [15:0] w;
        logic [39:0] r;
        logic        hw;
        arc_l |= p[11];
        on_l |= p[13];
        hw = p[3] | (|p[1:0]) | (|p[5:4]);
        if (l == 8'h4b)
            w = {p[3:0], p[4], 2'b00, p[5],
                 p[7:6], 5'h00, hw | tk_l | p[8] | p[7]};
        else
            w = {mf[m], p[12], arc_l, p[16:13],
                 on_l, hw | tk_l | p[9], p[10], 1'b0,
                 p[20:17]};
        ax(1'b0, l == 8'h4b ? 8'h04 : 8'h08, {16'h0, w}, 2'b00);
        host.ask(l, slow, r);
        chk("reply", {hx(w[15:12]), hx(w[11:8]), hx(w[7:4]), hx(w[3:0]), l}, r);
        if (l == 8'h53) arc_l = p[11];
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        ax(1'b0, 8'h00, 32'h1, 2'b00);
        ax(1'b0, 8'h18, 32'h0, 2'b10);
        ax(1'b1, 8'h04, 32'hffff, 2'b10);
        ax(1'b1, 8'h00, 32'h0, 2'b00);
        repeat (2) @(posedge aclk);
        chk("query_ready", 40'h0, 40'(query_ready));
        ax(1'b1, 8'h00, 32'h1, 2'b00);
        for (int i = 0; i < 8; i++) begin
            {rs, tk, m, p} <= tbl[i];
            @(posedge aclk);
            {rs, tk} <= 2'b00;
            tk_l = tk | (tk_l & ~rs);
            on_l = on_l & ~rs;
            repeat (3) @(posedge aclk);
            probe(8'h4b, i[0]);
            probe(8'h53, ~i[0]);
        end
        ax(1'b0, 8'h0c, 32'h0000_0010, 2'b00);
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        report_and_stop();
    end
endmodule
